/* hdl/adc_seq_pkg.sv */
// shared constants, trigger codes and state type for the sample sequencer
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_SEQ      = 4;
  localparam int NUM_STEP_MAX = 8;
  localparam int SEQ_W        = 2;
  localparam int STEP_W       = 3;
  localparam int PRIO_W       = 2;
  localparam int CHAN_SEL_W   = 4;
  localparam int NUM_EXT_CHAN = 8;
  localparam int DEPTH_SEQ0   = 8;
  localparam int DEPTH_SEQ1   = 4;
  localparam int DEPTH_SEQ2   = 4;
  localparam int DEPTH_SEQ3   = 1;

  // channel select: 0..7 external inputs, 8 the temperature sensor
  localparam logic [CHAN_SEL_W-1:0] TEMP_SENSOR_SEL = 4'h8;

  // ----------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------
  localparam int TRIG_W = 3;
  localparam logic [TRIG_W-1:0] TRIG_PROCESSOR = 3'h0;
  localparam logic [TRIG_W-1:0] TRIG_COMP0     = 3'h1;
  localparam logic [TRIG_W-1:0] TRIG_COMP1     = 3'h2;
  localparam logic [TRIG_W-1:0] TRIG_COMP2     = 3'h3;
  localparam logic [TRIG_W-1:0] TRIG_EXTERNAL  = 3'h4;
  localparam logic [TRIG_W-1:0] TRIG_TIMER     = 3'h5;
  localparam logic [TRIG_W-1:0] TRIG_ALWAYS    = 3'h6;

  // ----------------------------------------------------------------
  // averaging: factor code n averages 2**n samples up to 64, code 7 as 6, 0 bypasses
  // ----------------------------------------------------------------
  localparam int AVG_W = 3;
  localparam logic [AVG_W-1:0] AVG_OFF        = 3'h0;
  localparam logic [AVG_W-1:0] AVG_MAX_FACTOR = 3'h6;
  localparam int AVG_CNT_W = 7;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_ACC} seq_state_t;

  // number of steps that a sequence can hold
  function automatic int seq_depth(input logic [SEQ_W-1:0] s);
    case (s)
      2'h0:    seq_depth = DEPTH_SEQ0;
      2'h1:    seq_depth = DEPTH_SEQ1;
      2'h2:    seq_depth = DEPTH_SEQ2;
      default: seq_depth = DEPTH_SEQ3;
    endcase
  endfunction

endpackage

/* hdl/adc_averager.sv */
// hardware averager: sums 2**factor conversions and emits their mean
`timescale 1ns/1ps
`default_nettype none
module adc_averager
  import adc_seq_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [AVG_W-1:0]    averaging_factor,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  output logic                     avg_valid,
  output logic [SAMPLE_W-1:0]      avg_data
);

  localparam int ACC_W = SAMPLE_W + int'(AVG_MAX_FACTOR);

  typedef struct packed {
    logic [ACC_W-1:0]     acc;
    logic [AVG_CNT_W-1:0] count;
    logic                 avg_valid;
    logic [SAMPLE_W-1:0]  avg_data;
  } avg_state_t;

  avg_state_t q;
  avg_state_t next_q;
  logic [AVG_W-1:0]     factor;
  logic [AVG_CNT_W-1:0] target;
  logic [ACC_W-1:0]     sum;

  // codes above the largest factor are clamped rather than overflow the sum
  assign factor = (averaging_factor > AVG_MAX_FACTOR) ? AVG_MAX_FACTOR : averaging_factor;
  assign target = AVG_CNT_W'(1) << factor;
  assign sum    = q.acc + ACC_W'(sample_data);

  // ----------------------------------------------------------------
  // accumulate; factor zero gives a group of one, passing data through
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.avg_valid = 1'b0;
    if (sample_valid) begin
      if (q.count == target - AVG_CNT_W'(1)) begin
        next_q.avg_data  = SAMPLE_W'(sum >> factor);
        next_q.avg_valid = 1'b1;
        next_q.acc       = '0;
        next_q.count     = '0;
      end else begin
        next_q.acc   = sum;
        next_q.count = q.count + AVG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign avg_valid = q.avg_valid;
  assign avg_data  = q.avg_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_avg_bypass;
    (averaging_factor == AVG_OFF && sample_valid) |=>
      (avg_valid && avg_data == $past(sample_data));
  endproperty
  a_avg_bypass: assert property (p_avg_bypass) else $error("bypass did not pass sample");

  property p_avg_group;
    (avg_valid && $stable(averaging_factor)) |-> ($past(q.count) == target - AVG_CNT_W'(1));
  endproperty
  a_avg_group: assert property (p_avg_group) else $error("average emitted early");

endmodule
`default_nettype wire

/* hdl/adc_sample_sequencer.sv */
// four-sequence converter sequencer with priority, averaging and interrupts
// Summary of operation
// - steps select one of eight external inputs or the temperature sensor
// - four sequences, each with its own trigger source
// - sequence depths are eight, four, four and one steps
// - every step selects its own channel; repeats and any order allowed
// - the highest-priority triggered sequence is sampled first
// - strict priority, no fairness; low priorities may starve
// - averaging factors 2x to 64x over consecutive conversions
// - factor zero stores each conversion directly
// - averaging is common to all sequences and keeps full depth
// - averaging divides throughput by the factor
// - per-sequence interrupt clear stops the request
// - per-sequence interrupt mask
// - opening a mask clears any stale pending interrupt on the next edge; irq shows it until then
// - raw and masked status per sequence are visible
// - processor trigger acts only when source is processor
// - priorities 0 to 3, 0 highest, software keeps them distinct
// - overflow flag when a trigger finds unread results, sticky until cleared
// - always trigger repeats whenever no higher priority is active
`timescale 1ns/1ps
`default_nettype none
module adc_sample_sequencer
  import adc_seq_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                                                 clk,
  input  wire logic                                                 srst,
  input  wire logic [NUM_SEQ-1:0]                                   seq_enable,
  input  wire logic [NUM_SEQ-1:0][TRIG_W-1:0]                       trigger_source,
  input  wire logic [NUM_SEQ-1:0][PRIO_W-1:0]                       sequence_priority,
  input  wire logic [NUM_SEQ-1:0][NUM_STEP_MAX-1:0][CHAN_SEL_W-1:0] step_channel,
  input  wire logic [NUM_SEQ-1:0][NUM_STEP_MAX-1:0]                 step_end,
  input  wire logic [NUM_SEQ-1:0][NUM_STEP_MAX-1:0]                 step_int_enable,
  input  wire logic [AVG_W-1:0]                                     averaging_factor,
  input  wire logic [NUM_SEQ-1:0]                                   proc_trigger,
  input  wire logic [2:0]                                           comp_trigger,
  input  wire logic                                                 timer_trigger,
  input  wire logic                                                 ext_trigger_pin,
  input  wire logic [NUM_SEQ-1:0]                                   int_clear,
  input  wire logic [NUM_SEQ-1:0]                                   int_mask,
  input  wire logic                                                 masked_status_select,
  output logic [NUM_SEQ-1:0]                                        int_status,
  output logic [NUM_SEQ-1:0]                                        irq,
  input  wire logic [NUM_SEQ-1:0]                                   fifo_empty,
  input  wire logic [NUM_SEQ-1:0]                                   overflow_clear,
  output logic [NUM_SEQ-1:0]                                        overflow,
  output logic                                                      conv_start,
  output logic [CHAN_SEL_W-1:0]                                     conv_channel,
  input  wire logic                                                 conv_done,
  input  wire logic [SAMPLE_W-1:0]                                  conv_data,
  output logic                                                      result_valid,
  output logic [SEQ_W-1:0]                                          result_seq,
  output logic [STEP_W-1:0]                                         result_step,
  output logic [SAMPLE_W-1:0]                                       result_data
);

  if (SAMPLE_W < 1 || SAMPLE_W > 24) begin : g_bad_width
    $error("SAMPLE_W out of range");
  end

  typedef struct packed {
    seq_state_t            st;
    logic [SEQ_W-1:0]      cur;
    logic [STEP_W-1:0]     step;
    logic [NUM_SEQ-1:0]    pending;
    logic [NUM_SEQ-1:0]    raw;
    logic [NUM_SEQ-1:0]    ovf;
    logic [NUM_SEQ-1:0]    mask_q;
    logic                  ext_s1;
    logic                  ext_s2;
    logic                  ext_prev;
    logic                  conv_start;
    logic [CHAN_SEL_W-1:0] conv_channel;
    logic                  res_valid;
    logic [SEQ_W-1:0]      res_seq;
    logic [STEP_W-1:0]     res_step;
    logic [SAMPLE_W-1:0]   res_data;
  } seq_regs_t;

  seq_regs_t q;
  seq_regs_t next_q;

  logic                avg_valid;
  logic [SAMPLE_W-1:0] avg_data;
  logic [NUM_SEQ-1:0]  trig_evt;
  logic [NUM_SEQ-1:0]  candidates;
  logic [SEQ_W-1:0]    winner;
  logic [NUM_SEQ-1:0]  raw_set;
  logic                ext_rise;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest priority value wins; ties go to the lower index, which only
  // matters when software breaks the distinct-priority agreement
  function automatic logic [SEQ_W-1:0] pick_seq(input logic [NUM_SEQ-1:0] cand,
                                                input logic [NUM_SEQ-1:0][PRIO_W-1:0] prio);
    logic [SEQ_W-1:0]  best;
    logic [PRIO_W:0]   best_p;
    best   = '0;
    best_p = {1'b1, {PRIO_W{1'b0}}};
    for (int i = 0; i < NUM_SEQ; i++) begin
      if (cand[i] && {1'b0, prio[i]} < best_p) begin
        best   = SEQ_W'(i);
        best_p = {1'b0, prio[i]};
      end
    end
    return best;
  endfunction

  // any code above the last external input selects the temperature sensor
  function automatic logic [CHAN_SEL_W-1:0] map_chan(input logic [CHAN_SEL_W-1:0] sel);
    return (sel >= CHAN_SEL_W'(NUM_EXT_CHAN)) ? TEMP_SENSOR_SEL : sel;
  endfunction

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  assign ext_rise = q.ext_s2 && !q.ext_prev;

  always_comb begin
    for (int s = 0; s < NUM_SEQ; s++) begin
      case (trigger_source[s])
        TRIG_PROCESSOR: trig_evt[s] = proc_trigger[s];
        TRIG_COMP0:     trig_evt[s] = comp_trigger[0];
        TRIG_COMP1:     trig_evt[s] = comp_trigger[1];
        TRIG_COMP2:     trig_evt[s] = comp_trigger[2];
        TRIG_EXTERNAL:  trig_evt[s] = ext_rise;
        TRIG_TIMER:     trig_evt[s] = timer_trigger;
        TRIG_ALWAYS:    trig_evt[s] = 1'b1;
        default:        trig_evt[s] = 1'b0;
      endcase
    end
  end

  assign candidates = q.pending & seq_enable;
  assign winner     = pick_seq(candidates, sequence_priority);

  // ----------------------------------------------------------------
  // sequencer state machine and flags
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    raw_set = '0;
    next_q.conv_start = 1'b0;
    next_q.res_valid  = 1'b0;
    next_q.ext_s1   = ext_trigger_pin;
    next_q.ext_s2   = q.ext_s1;
    next_q.ext_prev = q.ext_s2;
    next_q.mask_q   = int_mask;
    case (q.st)
      ST_IDLE: begin
        if (|candidates) begin
          next_q.cur  = winner;
          next_q.step = '0;
          next_q.pending[winner] = 1'b0;
          if (!fifo_empty[winner]) begin
            next_q.ovf[winner] = 1'b1;
          end
          next_q.st = ST_START;
        end
      end
      ST_START: begin
        next_q.conv_start   = 1'b1;
        next_q.conv_channel = map_chan(step_channel[q.cur][q.step]);
        next_q.st           = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done) begin
          next_q.st = ST_ACC;
        end
      end
      ST_ACC: begin
        // one stored result per step, whatever the factor; the same step
        // is converted again until the averager has a full group
        if (avg_valid) begin
          next_q.res_valid = 1'b1;
          next_q.res_seq   = q.cur;
          next_q.res_step  = q.step;
          next_q.res_data  = avg_data;
          raw_set[q.cur]   = step_int_enable[q.cur][q.step];
          if (step_end[q.cur][q.step] || int'(q.step) == seq_depth(q.cur) - 1) begin
            next_q.st = ST_IDLE;
          end else begin
            next_q.step = q.step + STEP_W'(1);
            next_q.st   = ST_START;
          end
        end else begin
          next_q.st = ST_START;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
    // triggers latch after the start clear, so a new one is never lost
    next_q.pending = next_q.pending | (trig_evt & seq_enable);
    for (int s = 0; s < NUM_SEQ; s++) begin
      // a clear, or a mask just opening, drops stale status; a new event wins
      if (int_clear[s] || (int_mask[s] && !q.mask_q[s])) begin
        next_q.raw[s] = 1'b0;
      end
      if (raw_set[s]) begin
        next_q.raw[s] = 1'b1;
      end
      if (overflow_clear[s] && !(q.st == ST_IDLE && |candidates && winner == SEQ_W'(s)
                                 && !fifo_empty[s])) begin
        next_q.ovf[s] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // averager, common to every sequence
  // ----------------------------------------------------------------
  adc_averager #(
    .SAMPLE_W (SAMPLE_W)
  ) u_averager (
    .clk              (clk),
    .srst             (srst),
    .averaging_factor (averaging_factor),
    .sample_valid     (q.st == ST_WAIT && conv_done),
    .sample_data      (conv_data),
    .avg_valid        (avg_valid),
    .avg_data         (avg_data)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign irq          = q.raw & int_mask;
  assign int_status   = masked_status_select ? irq : q.raw;
  assign overflow     = q.ovf;
  assign conv_start   = q.conv_start;
  assign conv_channel = q.conv_channel;
  assign result_valid = q.res_valid;
  assign result_seq   = q.res_seq;
  assign result_step  = q.res_step;
  assign result_data  = q.res_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_step_depth;
    (q.st != ST_IDLE) |-> (int'(q.step) < seq_depth(q.cur));
  endproperty
  a_step_depth: assert property (p_step_depth) else $error("step beyond depth");

  property p_chan;
    conv_start |-> (conv_channel == map_chan(step_channel[q.cur][q.step])
                    && conv_channel <= TEMP_SENSOR_SEL);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel converted");

  property p_overflow_sticky;
    (|(q.ovf & ~overflow_clear)) |=> (|q.ovf);
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow lost");

  for (genvar s = 0; s < NUM_SEQ; s++) begin : g_seq_checks
    property p_proc_only;
      (trigger_source[s] == TRIG_PROCESSOR && $rose(q.pending[s])) |-> $past(proc_trigger[s]);
    endproperty
    a_proc_only: assert property (p_proc_only) else $error("pending without processor trigger");

    property p_clear;
      (int_clear[s] && !raw_set[s]) |=> !irq[s] ##1 (!irq[s] || $past(raw_set[s]));
    endproperty
    a_clear: assert property (p_clear) else $error("interrupt survived clear");

    property p_mask_open;
      ($rose(int_mask[s]) && !raw_set[s]) |=> !q.raw[s];
    endproperty
    a_mask_open: assert property (p_mask_open) else $error("stale interrupt on enable");

    property p_masked_view;
      (masked_status_select && !int_mask[s]) |-> (!int_status[s] && !irq[s]);
    endproperty
    a_masked_view: assert property (p_masked_view) else $error("masked status leaks");

    property p_prio;
      (q.st == ST_IDLE && candidates[s]) |-> (candidates[winner]
        && sequence_priority[winner] <= sequence_priority[s]) ##1 (q.st == ST_START);
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority chosen");
  end

endmodule
`default_nettype wire

/* verification/adc_core_model.sv */
// behavioural converter core answering conversion requests from the sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
  import adc_seq_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  conv_start,
  input  wire logic [CHAN_SEL_W-1:0] conv_channel,
  input  wire logic                  slow,
  input  wire logic                  wobble,
  output logic                       conv_done,
  output logic [SAMPLE_W-1:0]        conv_data,
  output var int                     conv_count
);
  logic                  busy;
  logic [2:0]            wait_cnt;
  logic [CHAN_SEL_W-1:0] chan;
  logic [SAMPLE_W-1:0]   last;
  logic [SAMPLE_W-1:0]   sample;

  // ------------------------------------------------------------
  // conversion engine
  // ------------------------------------------------------------
  // the sample carries its channel so steps can be told apart; wobble adds 2 on odd
  // conversions so that an average lands between two raw values
  assign sample = SAMPLE_W'({chan, 8'hA5})
                  + ((wobble && conv_count[0]) ? SAMPLE_W'(2) : SAMPLE_W'(0));

  // one conversion at a time; outside the done cycle the data lines show the inverse
  // of the last result, so a late capture by the sequencer cannot pass unnoticed
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~last;
    if (srst) begin
      busy       <= 1'b0;
      conv_count <= 0;
      last       <= '0;
    end else if (conv_start) begin
      busy     <= 1'b1;
      wait_cnt <= slow ? 3'h5 : 3'h1;
      chan     <= conv_channel;
    end else if (busy) begin
      if (wait_cnt == 3'h1) begin
        busy       <= 1'b0;
        conv_done  <= 1'b1;
        conv_data  <= sample;
        last       <= sample;
        conv_count <= conv_count + 1;
      end else begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/test_adc_sample_sequencer.sv */
// self-checking bench for the four-sequence converter sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_sample_sequencer
  import adc_seq_pkg::*;
;
  localparam int SW = 12;
  logic                                   clk, srst, timer_trigger, ext_trigger_pin;
  logic                                   masked_status_select, conv_start, conv_done;
  logic                                   result_valid, slow, wobble;
  logic [NUM_SEQ-1:0]                     seq_enable, proc_trigger, int_clear, int_mask;
  logic [NUM_SEQ-1:0]                     fifo_empty, overflow_clear, int_status, irq, overflow;
  logic [NUM_SEQ-1:0][TRIG_W-1:0]         trigger_source;
  logic [NUM_SEQ-1:0][PRIO_W-1:0]         sequence_priority;
  logic [NUM_SEQ-1:0][NUM_STEP_MAX-1:0][CHAN_SEL_W-1:0] step_channel;
  logic [NUM_SEQ-1:0][NUM_STEP_MAX-1:0]   step_end, step_int_enable;
  logic [AVG_W-1:0]                       averaging_factor;
  logic [2:0]                             comp_trigger;
  logic [CHAN_SEL_W-1:0]                  conv_channel;
  logic [SW-1:0]                          conv_data, result_data;
  logic [SEQ_W-1:0]                       result_seq;
  logic [STEP_W-1:0]                      result_step;
  logic [16:0]                            res_q[$];
  int                                     conv_count, n_fail, comparisons, c0, base;

  // ------------------------------------------------------------
  // design, converter model and result collector
  // ------------------------------------------------------------
  adc_sample_sequencer #(.SAMPLE_W(SW)) adc_sample_sequencer_inst (
    .clk(clk), .srst(srst), .seq_enable(seq_enable), .trigger_source(trigger_source),
    .sequence_priority(sequence_priority), .step_channel(step_channel), .step_end(step_end),
    .step_int_enable(step_int_enable), .averaging_factor(averaging_factor),
    .proc_trigger(proc_trigger), .comp_trigger(comp_trigger), .timer_trigger(timer_trigger),
    .ext_trigger_pin(ext_trigger_pin), .int_clear(int_clear), .int_mask(int_mask),
    .masked_status_select(masked_status_select), .int_status(int_status), .irq(irq),
    .fifo_empty(fifo_empty), .overflow_clear(overflow_clear), .overflow(overflow),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .result_valid(result_valid), .result_seq(result_seq),
    .result_step(result_step), .result_data(result_data));

  adc_core_model #(.SAMPLE_W(SW)) adc_core_model_inst (
    .clk(clk), .srst(srst), .conv_start(conv_start), .conv_channel(conv_channel), .slow(slow),
    .wobble(wobble), .conv_done(conv_done), .conv_data(conv_data), .conv_count(conv_count));

  always #10 clk = ~clk;

  // results are one-cycle pulses, so they are captured where they have settled
  always @(negedge clk) begin
    if (result_valid === 1'b1) begin
      res_q.push_back({result_seq, result_step, result_data});
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input int i, input logic [SEQ_W-1:0] s, input logic [STEP_W-1:0] st,
                         input logic [SW-1:0] d);
    chk_val({15'h0, res_q[i]}, {15'h0, s, st, d});
  endtask

  // bounded wait for a number of collected results; running out ends the run
  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (res_q.size() < n && k < 3000) begin
      cyc(1);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      $display("ERROR t=%0t results got=%h exp=%h", $time, res_q.size(), n);
      print_verdict();
    end
  endtask

  task automatic trig(input logic [NUM_SEQ-1:0] m);
    proc_trigger = m;
    cyc(1);
    proc_trigger = '0;
  endtask

  // temperature codes fold onto 8; an averaged wobbling input lands one above the base
  function automatic logic [SW-1:0] expd(input logic [CHAN_SEL_W-1:0] ch, input logic add);
    expd = SW'({(ch >= 4'h8) ? 4'h8 : ch, 8'hA5}) + (add ? SW'(1) : SW'(0));
  endfunction

  // one processor-started run of sequence s that must give n results in step order
  task automatic run_seq(input int s, input int n);
    res_q.delete();
    trigger_source[s] = TRIG_PROCESSOR;
    trig(NUM_SEQ'(1 << s));
    wait_res(n);
    cyc(40);
    chk_val(res_q.size(), n);
    for (int i = 0; i < n; i++) begin
      chk_res(i, SEQ_W'(s), STEP_W'(i), expd(step_channel[s][i], wobble));
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0; srst = 1'b1; seq_enable = 4'hF; proc_trigger = '0; int_clear = '0;
    int_mask = '0; fifo_empty = 4'hF; overflow_clear = '0; trigger_source = {4{3'h7}};
    sequence_priority = {2'h3, 2'h2, 2'h1, 2'h0}; step_channel = '0; step_end = '0;
    step_int_enable = '0; averaging_factor = AVG_OFF; comp_trigger = '0; timer_trigger = 1'b0;
    ext_trigger_pin = 1'b0; masked_status_select = 1'b0; slow = 1'b0; wobble = 1'b0;
    n_fail = 0; comparisons = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    cyc(2);
    // full depths of sequences 0 and 1, an early end in 2, repeated channels, the temperature code and a slow converter
    step_channel[0] = {4'h2, 4'h5, 4'h1, 4'h9, 4'h7, 4'h0, 4'h3, 4'h3};
    step_channel[1][3:0] = {4'h6, 4'h6, 4'h8, 4'h4};
    step_channel[2][1:0] = {4'h7, 4'h1};
    step_channel[3][0] = 4'h5;
    step_end[2][1] = 1'b1;
    step_end[3][0] = 1'b1;
    run_seq(0, 8);
    slow = 1'b1;
    run_seq(1, 4);
    run_seq(2, 2);
    slow = 1'b0;
    chk_val(overflow, 4'h0);
    $display("test depth and channels done");
    // every averaging code, 7 folding onto 6: the mean, at 2**n conversions per result
    for (int f = 0; f <= 7; f++) begin
      averaging_factor = AVG_W'(f);
      wobble = (f != 0);
      c0 = conv_count;
      run_seq(3, 1);
      chk_val(conv_count - c0, 1 << ((f > 6) ? 6 : f));
    end
    averaging_factor = 3'h2;
    run_seq(1, 4);
    averaging_factor = AVG_OFF;
    wobble = 1'b0;
    $display("test averaging done");
    // simultaneous triggers under both priority orders
    for (int p = 0; p < 2; p++) begin
      sequence_priority[1] = p ? 2'h2 : 2'h1;
      sequence_priority[2] = p ? 2'h1 : 2'h2;
      res_q.delete();
      trig(4'h6);
      wait_res(6);
      for (int i = 0; i < 6; i++) begin
        chk_val(res_q[i][16:15],
                (p == 0) ? ((i < 4) ? 1 : 2) : ((i < 2) ? 2 : 1));
      end
    end
    $display("test priority done");
    // continuous trigger repeats, then a higher continuous one starves it
    res_q.delete();
    trigger_source[2] = TRIG_ALWAYS;
    wait_res(6);
    for (int i = 0; i < 6; i++) chk_val(res_q[i][16:15], 2);
    base = res_q.size();
    trigger_source[0] = TRIG_ALWAYS;
    wait_res(base + 20);
    for (int i = base + 4; i < base + 20; i++) chk_val(res_q[i][16:15], 0);
    trigger_source[0] = 3'h7;
    trigger_source[2] = 3'h7;
    cyc(300);
    $display("test continuous trigger done");
    // each hardware trigger source in turn, then a processor trigger that must be ignored
    for (int code = 1; code <= 5; code++) begin
      res_q.delete();
      trigger_source[3] = TRIG_W'(code);
      comp_trigger = (code <= 3) ? 3'(1 << (code - 1)) : 3'h0;
      timer_trigger = (code == 5);
      ext_trigger_pin = (code == 4);
      cyc(1);
      comp_trigger = 3'h0;
      timer_trigger = 1'b0;
      cyc(3);
      ext_trigger_pin = 1'b0;
      wait_res(1);
      cyc(20);
      chk_val(res_q.size(), 1);
    end
    res_q.delete();
    c0 = conv_count;
    trig(4'h8);
    cyc(60);
    chk_val(conv_count - c0, 0);
    // a disabled sequence ignores even a trigger from its own source
    seq_enable[3] = 1'b0;
    trigger_source[3] = TRIG_PROCESSOR;
    trig(4'h8);
    cyc(60);
    chk_val(conv_count - c0, 0);
    seq_enable[3] = 1'b1;
    run_seq(3, 1);
    $display("test trigger sources done");
    // overflow when a trigger finds unread results; sticky until cleared
    fifo_empty[3] = 1'b0;
    run_seq(3, 1);
    chk_val(overflow, 4'h8);
    fifo_empty[3] = 1'b1;
    cyc(10);
    chk_val(overflow, 4'h8);
    overflow_clear[3] = 1'b1;
    cyc(1);
    overflow_clear[3] = 1'b0;
    cyc(2);
    chk_val(overflow, 4'h0);
    $display("test overflow done");
    // raw and masked status, clear, stale clear on mask opening, request line
    step_int_enable[3][0] = 1'b1;
    run_seq(3, 1);
    chk_val({int_status, irq}, 8'h80);
    masked_status_select = 1'b1;
    cyc(1);
    chk_val(int_status, 4'h0);
    int_clear[3] = 1'b1;
    cyc(1);
    int_clear[3] = 1'b0;
    cyc(2);
    masked_status_select = 1'b0;
    cyc(1);
    chk_val(int_status, 4'h0);
    run_seq(3, 1);
    chk_val(int_status, 4'h8);
    int_mask[3] = 1'b1;
    cyc(2);
    chk_val({int_status, irq}, 8'h00);
    run_seq(3, 1);
    chk_val({int_status, irq}, 8'h88);
    masked_status_select = 1'b1;
    cyc(1);
    chk_val(int_status, 4'h8);
    int_clear[3] = 1'b1;
    cyc(1);
    int_clear[3] = 1'b0;
    cyc(2);
    chk_val({int_status, irq}, 8'h00);
    $display("test interrupts done");
    print_verdict();
  end
endmodule
`default_nettype wire
